// File: design/mmu_xlate_fault.sv
// Purpose: Selects real, block or page translation and classifies translation faults.
// Assumes: One access in flight; the page table search is done by the memory side.
// Notes: A data request is taken ahead of a waiting instruction request.
//
// Summary of operation
// [R1] Translation disabled for the access type: physical address equals effective address.
// [R2] Block hit is checked against block protection; failure raises a storage exception.
// [R3] No block match: top four address bits pick one of 16 segment registers.
// [R4] Direct-store select clear means page translation; set means a direct-store fault.
// [R5] Page translation forms a 52-bit virtual address from segment and address.
// [R6] Separate instruction and data translation caches forward the physical address on hit.
// [R7] Cache miss searches the page table, refills the cache and retries the lookup.
// [R8] A found page translation is checked against page protection bits.
// [R9] No translation found: page fault, status bit 1 in the matching status word.
// [R10] Block or page protection violation sets status bit 4 of the matching word.
// [R11] Fetch from a no-execute segment faults with save-restore status bit 3.
// [R12] Fetch from a direct-store segment faults with save-restore status bit 3.
// [R13] Data access to a direct-store segment faults with data fault status bit 5.
// [R14] Fetch from a guarded block or guarded page faults with status bit 3.
// [R15] Data accesses with data translation off raise no translation exception.
// [R16] Every translation fault reports the address of the faulting instruction.
// [R17] A block match supplies the address and overrides the parallel page path.
// [R18] Instruction and data translation enables act independently of each other.

`timescale 1ns/100ps
`default_nettype none

module mmu_xlate_fault (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Translation enables
	input wire logic instr_xlate_enable_i,
	input wire logic data_xlate_enable_i,
	// Segment register load
	input wire logic seg_wr_i,
	input wire logic [mmu_pkg::SEG_IDX_W-1:0] seg_wr_idx_i,
	input wire mmu_pkg::seg_s seg_wr_data_i,
	// Block array load
	input wire logic blk_wr_i,
	input wire logic blk_wr_instr_i,
	input wire logic [mmu_pkg::BLK_IDX_W-1:0] blk_wr_idx_i,
	input wire mmu_pkg::blk_s blk_wr_entry_i,
	// Translation cache maintenance
	input wire logic tlb_flush_i,
	// Access requests
	input wire logic instr_req_valid_i,
	input wire mmu_pkg::req_s instr_req_i,
	input wire logic data_req_valid_i,
	input wire mmu_pkg::req_s data_req_i,
	output logic req_ready_o,
	// Access result
	output logic resp_valid_o,
	output mmu_pkg::resp_s resp_o,
	// Page table search
	output logic walk_req_o,
	output logic [mmu_pkg::VADDR_W-1:0] walk_vaddr_o,
	input wire logic walk_done_i,
	input wire logic walk_found_i,
	input wire mmu_pkg::pte_s walk_pte_i
);

	// ****************************************
	// State
	// ****************************************
	mmu_pkg::state_e state_reg;
	mmu_pkg::state_e state_next;
	mmu_pkg::req_s cur_req_reg;
	logic cur_instr_reg;
	mmu_pkg::seg_s seg_reg [mmu_pkg::SEG_COUNT];
	logic ready_reg;
	logic resp_valid_reg;
	mmu_pkg::resp_s resp_reg;
	logic walk_req_reg;
	logic [mmu_pkg::VADDR_W-1:0] walk_vaddr_reg;

	// ****************************************
	// Request intake
	// ****************************************
	logic take_req;
	logic take_data;
	logic [31:0] ea;

	assign take_req = ready_reg && (data_req_valid_i || instr_req_valid_i);
	assign take_data = data_req_valid_i;
	assign ea = cur_req_reg.effective_addr;

	// ****************************************
	// Path selection
	// ****************************************
	logic xlate_on;
	logic ib_hit;
	logic db_hit;
	mmu_pkg::blk_s ib_entry;
	mmu_pkg::blk_s db_entry;
	logic [31:0] ib_pa;
	logic [31:0] db_pa;
	logic blk_hit;
	mmu_pkg::blk_s blk_entry;
	logic [31:0] blk_pa;
	mmu_pkg::seg_s seg;
	logic [mmu_pkg::VADDR_W-1:0] vaddr;
	logic itlb_hit;
	logic dtlb_hit;
	mmu_pkg::pte_s itlb_pte;
	mmu_pkg::pte_s dtlb_pte;
	logic tlb_hit;
	mmu_pkg::pte_s page_table_entry;

	// Each side looks only at its own enable, so fetch and data may differ.
	assign xlate_on = cur_instr_reg ? instr_xlate_enable_i : data_xlate_enable_i; // [R18]
	assign blk_hit = cur_instr_reg ? ib_hit : db_hit;
	assign blk_entry = cur_instr_reg ? ib_entry : db_entry;
	assign blk_pa = cur_instr_reg ? ib_pa : db_pa;
	assign seg = seg_reg[ea[31:28]]; // [R3]
	assign vaddr = {seg.vsid, ea[27:0]}; // [R5]
	assign tlb_hit = cur_instr_reg ? itlb_hit : dtlb_hit; // [R6]
	assign page_table_entry = cur_instr_reg ? itlb_pte : dtlb_pte;

	// ****************************************
	// Protection
	// ****************************************
	logic is_write;
	logic blk_perm;
	logic page_key;
	logic page_perm;

	assign is_write = !cur_instr_reg && cur_req_reg.store;
	assign blk_perm = is_write ? (blk_entry.pp == mmu_pkg::PP_RW)
		: (blk_entry.pp != mmu_pkg::PP_NONE); // [R2]
	assign page_key = cur_req_reg.supervisor ? seg.key_sup : seg.key_user;
	assign page_perm = is_write
		? (page_key ? (page_table_entry.pp == mmu_pkg::PP_RW) : (page_table_entry.pp != mmu_pkg::PP_RO))
		: !(page_key && (page_table_entry.pp == mmu_pkg::PP_NONE)); // [R8]

	// ****************************************
	// Classification
	// ****************************************
	mmu_pkg::result_e result;

	// Order matters: a block match hides the page path entirely, and segment
	// faults are taken before the caches are consulted.
	assign result = !xlate_on ? mmu_pkg::RES_REAL // [R1] [R15]
		: blk_hit ? ((cur_instr_reg && blk_entry.block_guarded_bit) ? mmu_pkg::RES_BIT3 // [R14]
			: !blk_perm ? mmu_pkg::RES_PROT // [R2] [R10]
			: mmu_pkg::RES_BLOCK) // [R17]
		: seg.direct_store_select ? (cur_instr_reg ? mmu_pkg::RES_BIT3 // [R4] [R12]
			: mmu_pkg::RES_DSEG) // [R13]
		: (cur_instr_reg && seg.no_exec_bit) ? mmu_pkg::RES_BIT3 // [R11]
		: !tlb_hit ? mmu_pkg::RES_MISS // [R7]
		: (cur_instr_reg && page_table_entry.page_guarded_bit) ? mmu_pkg::RES_BIT3 // [R14]
		: !page_perm ? mmu_pkg::RES_PROT // [R8] [R10]
		: mmu_pkg::RES_PAGE; // [R6]

	logic lookup_fault;
	logic [4:0] lookup_bit;
	logic [31:0] lookup_pa;
	logic walk_fault;

	assign lookup_fault = (result == mmu_pkg::RES_PROT) || (result == mmu_pkg::RES_BIT3)
		|| (result == mmu_pkg::RES_DSEG);
	assign lookup_bit = (result == mmu_pkg::RES_PROT) ? mmu_pkg::ST_PROT
		: (result == mmu_pkg::RES_BIT3) ? mmu_pkg::ST_NO_EXEC
		: mmu_pkg::ST_DIRECT_STORE;
	assign lookup_pa = (result == mmu_pkg::RES_BLOCK) ? blk_pa // [R17]
		: (result == mmu_pkg::RES_PAGE) ? {page_table_entry.rpn, ea[mmu_pkg::PAGE_OFS_W-1:0]}
		: ea; // [R1]
	assign walk_fault = (state_reg == mmu_pkg::ST_WALK) && walk_done_i && !walk_found_i; // [R9]

	// ****************************************
	// Response assembly
	// ****************************************
	logic resp_fire;
	logic resp_fault;
	logic [4:0] resp_bit;
	logic [0:31] status_vec;
	mmu_pkg::resp_s resp_next;

	assign resp_fire = ((state_reg == mmu_pkg::ST_LOOKUP) && (result != mmu_pkg::RES_MISS))
		|| walk_fault;
	assign resp_fault = walk_fault || lookup_fault;
	assign resp_bit = walk_fault ? mmu_pkg::ST_PAGE_FAULT : lookup_bit;
	assign status_vec = resp_fault ? (mmu_pkg::ST_BIT0 >> resp_bit) : mmu_pkg::ST_NONE;

	assign resp_next.phys_addr = resp_fault ? 32'h0000_0000 : lookup_pa;
	assign resp_next.is_instr = cur_instr_reg;
	assign resp_next.instr_storage_exception = resp_fault && cur_instr_reg;
	assign resp_next.data_storage_exception = resp_fault && !cur_instr_reg;
	assign resp_next.save_restore_status = cur_instr_reg ? status_vec : mmu_pkg::ST_NONE;
	assign resp_next.data_fault_status = cur_instr_reg ? mmu_pkg::ST_NONE : status_vec;
	assign resp_next.fault_pc = resp_fault ? cur_req_reg.pc : 32'h0000_0000; // [R16]
	assign resp_next.fault_ea = resp_fault ? ea : 32'h0000_0000;

	// ****************************************
	// Sequencing
	// ****************************************
	logic fill_i_side;
	logic fill_d_side;
	logic walk_hit;

	assign walk_hit = (state_reg == mmu_pkg::ST_WALK) && walk_done_i && walk_found_i;
	assign fill_i_side = walk_hit && cur_instr_reg; // [R7]
	assign fill_d_side = walk_hit && !cur_instr_reg; // [R7]

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			mmu_pkg::ST_IDLE: begin
				if (take_req) begin
					state_next = mmu_pkg::ST_LOOKUP;
				end
			end
			mmu_pkg::ST_LOOKUP: begin
				if (result == mmu_pkg::RES_MISS) begin
					state_next = mmu_pkg::ST_WALK;
				end else begin
					state_next = mmu_pkg::ST_IDLE;
				end
			end
			mmu_pkg::ST_WALK: begin
				// After the refill the retry lookup is bound to hit.
				if (walk_done_i) begin
					state_next = walk_found_i ? mmu_pkg::ST_LOOKUP : mmu_pkg::ST_IDLE; // [R7]
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			state_reg <= mmu_pkg::ST_IDLE;
			ready_reg <= 1'b0;
			cur_instr_reg <= 1'b0;
			cur_req_reg <= '0;
		end else begin
			state_reg <= state_next;
			ready_reg <= (state_next == mmu_pkg::ST_IDLE) && !take_req;
			if (take_req) begin
				cur_instr_reg <= !take_data;
				cur_req_reg <= take_data ? data_req_i : instr_req_i;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			resp_valid_reg <= 1'b0;
			resp_reg <= '0;
		end else begin
			resp_valid_reg <= resp_fire;
			if (resp_fire) begin
				resp_reg <= resp_next;
			end
		end
	end

	// The search request stays up as a level until the memory side answers.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			walk_req_reg <= 1'b0;
			walk_vaddr_reg <= '0;
		end else begin
			walk_req_reg <= (state_next == mmu_pkg::ST_WALK); // [R7]
			if ((state_reg == mmu_pkg::ST_LOOKUP) && (result == mmu_pkg::RES_MISS)) begin
				walk_vaddr_reg <= vaddr; // [R5]
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < int'(mmu_pkg::SEG_COUNT); i++) begin
				seg_reg[i] <= '0;
			end
		end else if (seg_wr_i) begin
			seg_reg[seg_wr_idx_i] <= seg_wr_data_i;
		end
	end

	// ****************************************
	// Block arrays and translation caches
	// ****************************************
	block_array u_iblk (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.wr_i(blk_wr_i && blk_wr_instr_i),
		.wr_idx_i(blk_wr_idx_i),
		.wr_entry_i(blk_wr_entry_i),
		.ea_i(ea),
		.supervisor_i(cur_req_reg.supervisor),
		.hit_o(ib_hit),
		.entry_o(ib_entry),
		.phys_addr_o(ib_pa)
	);

	block_array u_dblk (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.wr_i(blk_wr_i && !blk_wr_instr_i),
		.wr_idx_i(blk_wr_idx_i),
		.wr_entry_i(blk_wr_entry_i),
		.ea_i(ea),
		.supervisor_i(cur_req_reg.supervisor),
		.hit_o(db_hit),
		.entry_o(db_entry),
		.phys_addr_o(db_pa)
	);

	xlate_cache u_itlb (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.flush_i(tlb_flush_i),
		.fill_i(fill_i_side),
		.fill_pte_i(walk_pte_i),
		.vaddr_i(vaddr),
		.hit_o(itlb_hit),
		.pte_o(itlb_pte)
	);

	xlate_cache u_dtlb (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.flush_i(tlb_flush_i),
		.fill_i(fill_d_side),
		.fill_pte_i(walk_pte_i),
		.vaddr_i(vaddr),
		.hit_o(dtlb_hit),
		.pte_o(dtlb_pte)
	);

	// ****************************************
	// Outputs
	// ****************************************
	assign req_ready_o = ready_reg;
	assign resp_valid_o = resp_valid_reg;
	assign resp_o = resp_reg;
	assign walk_req_o = walk_req_reg;
	assign walk_vaddr_o = walk_vaddr_reg;

endmodule : mmu_xlate_fault

`default_nettype wire

// File: design/mmu_pkg.sv
// Purpose: Shared constants, types and carriers of the address translation unit.
// Assumes: 32-bit effective and physical addresses, 4-Kbyte pages.
// Notes: Status vectors are numbered from bit 0 at the most significant end.

package mmu_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int unsigned SEG_COUNT = 16;
	localparam int unsigned SEG_IDX_W = 4;
	localparam int unsigned VADDR_W = 52;
	localparam int unsigned VSID_W = 24;
	localparam int unsigned RPN_W = 20;
	localparam int unsigned PAGE_OFS_W = 12;
	localparam int unsigned BLK_COUNT = 4;
	localparam int unsigned BLK_IDX_W = 2;
	localparam int unsigned TLB_COUNT = 16;
	localparam int unsigned TLB_IDX_W = 4;
	localparam int unsigned TLB_TAG_W = VADDR_W - PAGE_OFS_W - TLB_IDX_W;

	// ****************************************
	// Status bit positions
	// ****************************************
	localparam logic [4:0] ST_PAGE_FAULT = 5'h01;
	localparam logic [4:0] ST_NO_EXEC = 5'h03;
	localparam logic [4:0] ST_PROT = 5'h04;
	localparam logic [4:0] ST_DIRECT_STORE = 5'h05;
	localparam logic [0:31] ST_BIT0 = 32'h8000_0000;
	localparam logic [0:31] ST_NONE = 32'h0000_0000;

	// ****************************************
	// Protection encodings
	// ****************************************
	localparam logic [1:0] PP_NONE = 2'h0;
	localparam logic [1:0] PP_RW = 2'h2;
	localparam logic [1:0] PP_RO = 2'h3;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic direct_store_select;
		logic key_sup;
		logic key_user;
		logic no_exec_bit;
		logic [VSID_W-1:0] vsid;
	} seg_s;

	typedef struct packed {
		logic valid;
		logic [14:0] bepi;
		logic [10:0] len_mask;
		logic sup_valid;
		logic user_valid;
		logic [14:0] brpn;
		logic [1:0] pp;
		logic block_guarded_bit;
	} blk_s;

	typedef struct packed {
		logic [RPN_W-1:0] rpn;
		logic [1:0] pp;
		logic page_guarded_bit;
	} pte_s;

	typedef struct packed {
		logic [31:0] effective_addr;
		logic [31:0] pc;
		logic store;
		logic supervisor;
	} req_s;

	typedef struct packed {
		logic [31:0] phys_addr;
		logic is_instr;
		logic instr_storage_exception;
		logic data_storage_exception;
		logic [0:31] save_restore_status;
		logic [0:31] data_fault_status;
		logic [31:0] fault_pc;
		logic [31:0] fault_ea;
	} resp_s;

	typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_WALK} state_e;

	typedef enum logic [2:0] {
		RES_REAL, RES_BLOCK, RES_PAGE, RES_MISS, RES_PROT, RES_BIT3, RES_DSEG
	} result_e;

endpackage : mmu_pkg

// File: design/block_array.sv
// Purpose: Block translation array with parallel match of all entries.
// Assumes: Entries are loaded one at a time through the write port.
// Notes: The lowest matching index wins when software sets up overlaps.

`timescale 1ns/100ps
`default_nettype none

module block_array (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Entry load
	input wire logic wr_i,
	input wire logic [mmu_pkg::BLK_IDX_W-1:0] wr_idx_i,
	input wire mmu_pkg::blk_s wr_entry_i,
	// Lookup
	input wire logic [31:0] ea_i,
	input wire logic supervisor_i,
	output logic hit_o,
	output mmu_pkg::blk_s entry_o,
	output logic [31:0] phys_addr_o
);

	mmu_pkg::blk_s entry_reg [mmu_pkg::BLK_COUNT];
	logic [mmu_pkg::BLK_COUNT-1:0] match;
	logic [mmu_pkg::BLK_IDX_W-1:0] sel [mmu_pkg::BLK_COUNT+1];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < int'(mmu_pkg::BLK_COUNT); i++) begin
				entry_reg[i] <= '0;
			end
		end else if (wr_i) begin
			entry_reg[wr_idx_i] <= wr_entry_i;
		end
	end

	// Walking from the top down leaves the lowest matching index selected.
	assign sel[mmu_pkg::BLK_COUNT] = '0;
	for (genvar g = 0; g < mmu_pkg::BLK_COUNT; g++) begin : g_ent
		assign match[g] = entry_reg[g].valid
			&& (supervisor_i ? entry_reg[g].sup_valid : entry_reg[g].user_valid)
			&& (ea_i[31:28] == entry_reg[g].bepi[14:11])
			&& ((ea_i[27:17] & ~entry_reg[g].len_mask)
				== (entry_reg[g].bepi[10:0] & ~entry_reg[g].len_mask));
		assign sel[g] = match[g] ? mmu_pkg::BLK_IDX_W'(g) : sel[g+1];
	end

	assign hit_o = |match;
	assign entry_o = entry_reg[sel[0]];
	assign phys_addr_o = {entry_o.brpn[14:11],
		(ea_i[27:17] & entry_o.len_mask) | (entry_o.brpn[10:0] & ~entry_o.len_mask),
		ea_i[16:0]};

endmodule : block_array

`default_nettype wire

// File: design/xlate_cache.sv
// Purpose: Direct-mapped on-chip cache of page translations.
// Assumes: A refill write lands before the retry lookup in the next cycle.
// Notes: Flush drops every entry; a refill in the same cycle still lands.

`timescale 1ns/100ps
`default_nettype none

module xlate_cache (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Maintenance and refill
	input wire logic flush_i,
	input wire logic fill_i,
	input wire mmu_pkg::pte_s fill_pte_i,
	// Lookup
	input wire logic [mmu_pkg::VADDR_W-1:0] vaddr_i,
	output logic hit_o,
	output mmu_pkg::pte_s pte_o
);

	logic [mmu_pkg::TLB_COUNT-1:0] valid_reg;
	logic [mmu_pkg::TLB_TAG_W-1:0] tag_reg [mmu_pkg::TLB_COUNT];
	mmu_pkg::pte_s pte_reg [mmu_pkg::TLB_COUNT];
	logic [mmu_pkg::TLB_IDX_W-1:0] idx;
	logic [mmu_pkg::TLB_TAG_W-1:0] tag;

	assign idx = vaddr_i[mmu_pkg::PAGE_OFS_W +: mmu_pkg::TLB_IDX_W];
	assign tag = vaddr_i[mmu_pkg::VADDR_W-1 -: mmu_pkg::TLB_TAG_W];
	assign hit_o = valid_reg[idx] && (tag_reg[idx] == tag);
	assign pte_o = pte_reg[idx];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			valid_reg <= '0;
		end else begin
			if (flush_i) begin
				valid_reg <= '0;
			end
			if (fill_i) begin
				valid_reg[idx] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (fill_i) begin
			tag_reg[idx] <= tag;
			pte_reg[idx] <= fill_pte_i;
		end
	end

endmodule : xlate_cache

`default_nettype wire

// File: tb/mmu_xlate_fault_properties.sv
// Purpose: Port-level checks of the translation select and fault unit.
// Assumes: The requester holds the request fields until the response arrives.
// Notes: Bound to every instance of the unit.

`timescale 1ns/100ps
`default_nettype none

module mmu_xlate_fault_properties (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Requests and enables
	input wire logic instr_xlate_enable_i,
	input wire logic data_xlate_enable_i,
	input wire logic instr_req_valid_i,
	input wire mmu_pkg::req_s instr_req_i,
	input wire logic data_req_valid_i,
	input wire mmu_pkg::req_s data_req_i,
	input wire logic req_ready_o,
	// Results and search port
	input wire logic resp_valid_o,
	input wire mmu_pkg::resp_s resp_o,
	input wire logic walk_req_o,
	input wire logic walk_done_i,
	input wire logic walk_found_i
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	wire logic ri = resp_valid_o && resp_o.is_instr;
	wire logic rd = resp_valid_o && !resp_o.is_instr;
	wire logic flt = resp_o.instr_storage_exception || resp_o.data_storage_exception;
	wire logic [0:31] srr = resp_o.save_restore_status;
	wire logic [0:31] dfs = resp_o.data_fault_status;

	sequence take_s;
		req_ready_o && (instr_req_valid_i || data_req_valid_i);
	endsequence
	sequence found_s;
		walk_req_o && walk_done_i && walk_found_i;
	endsequence
	sequence lost_s;
		walk_req_o && walk_done_i && !walk_found_i;
	endsequence

	a_take_then_answer: assert property (take_s |=> !req_ready_o ##1 (resp_valid_o || walk_req_o))
		else $error("no result or search two cycles after a take");
	a_instr_real_path: assert property (ri && !instr_xlate_enable_i |-> !flt && resp_o.phys_addr == instr_req_i.effective_addr)
		else $error("fetch with translation off not passed through");
	a_data_real_path: assert property (rd && !data_xlate_enable_i |-> !flt && resp_o.phys_addr == data_req_i.effective_addr)
		else $error("data access with translation off faulted or moved");
	a_fault_pc_saved: assert property (resp_valid_o && flt |-> resp_o.fault_pc == (ri ? instr_req_i.pc : data_req_i.pc))
		else $error("faulting instruction address not saved");
	a_instr_status_bits: assert property (ri && flt |-> resp_o.instr_storage_exception && dfs == 32'h0 && srr inside {32'h4000_0000, 32'h1000_0000, 32'h0800_0000})
		else $error("fetch fault status malformed");
	a_data_status_bits: assert property (rd && flt |-> resp_o.data_storage_exception && srr == 32'h0 && dfs inside {32'h4000_0000, 32'h0800_0000, 32'h0400_0000})
		else $error("data fault status malformed");
	a_retry_hits: assert property (found_s |=> !resp_valid_o ##1 (resp_valid_o && !walk_req_o))
		else $error("no retry result after a found search");
	a_lost_page_fault: assert property (lost_s |=> resp_valid_o && (srr == 32'h4000_0000 || dfs == 32'h4000_0000))
		else $error("page fault not raised after a failed search");
	a_walk_holds: assert property (walk_req_o && !walk_done_i |=> walk_req_o)
		else $error("search request dropped early");
	a_walk_drops: assert property (walk_req_o && walk_done_i |=> !walk_req_o)
		else $error("search request held after done");
endmodule : mmu_xlate_fault_properties

bind mmu_xlate_fault mmu_xlate_fault_properties i_props (.sys_clk_i, .rst_b_i,
	.instr_xlate_enable_i, .data_xlate_enable_i, .instr_req_valid_i, .instr_req_i,
	.data_req_valid_i, .data_req_i, .req_ready_o, .resp_valid_o, .resp_o, .walk_req_o,
	.walk_done_i, .walk_found_i);

`default_nettype wire

// File: tb/page_table_model.sv
// Purpose: Memory side that answers page table searches.
// Assumes: The bench chooses outcome, entry and latency before each access.
// Notes: Entry lines carry inverted data outside the done pulse.

`timescale 1ns/100ps
`default_nettype none

module page_table_model (
	// Clock
	input wire logic sys_clk_i,
	// Search port
	input wire logic walk_req_i,
	input wire logic [mmu_pkg::VADDR_W-1:0] walk_vaddr_i,
	output var logic walk_done_o,
	output var logic walk_found_o,
	output var mmu_pkg::pte_s walk_pte_o,
	// Behaviour set by the bench
	input wire logic found_i,
	input wire mmu_pkg::pte_s pte_i,
	input wire logic [3:0] lat_i,
	output var int walks_o,
	output var logic [mmu_pkg::VADDR_W-1:0] last_va_o
);
	initial begin
		walk_done_o = 1'b0;
		walk_found_o = 1'b0;
		walk_pte_o = '0;
		walks_o = 0;
		last_va_o = '0;
	end

	// A stale entry is never left on the lines, so a late sample shows up as wrong data.
	always begin
		@(negedge sys_clk_i);
		if (walk_req_i === 1'b1) begin
			walks_o = walks_o + 1;
			last_va_o = walk_vaddr_i;
			repeat (lat_i) @(negedge sys_clk_i);
			walk_done_o = 1'b1;
			walk_found_o = found_i;
			walk_pte_o = pte_i;
			@(negedge sys_clk_i);
			walk_done_o = 1'b0;
			walk_found_o = ~found_i;
			walk_pte_o = ~pte_i;
		end
	end
endmodule : page_table_model

`default_nettype wire

// File: tb/tb_mmu_xlate_fault.sv
// Purpose: Self-checking bench of the translation select and fault unit.
// Assumes: Inputs change at the falling clock edge only.
// Notes: The cache is flushed before each pair of identical accesses.

`timescale 1ns/100ps
`default_nettype none

module tb_mmu_xlate_fault;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ixe = 1'b0;
	logic dxe = 1'b0;
	logic seg_wr = 1'b0;
	logic [3:0] seg_idx = '0;
	mmu_pkg::seg_s seg_d = '0;
	logic blk_wr = 1'b0;
	logic blk_i = 1'b0;
	logic [1:0] blk_idx = '0;
	mmu_pkg::blk_s blk_d = '0;
	logic flush = 1'b0;
	logic iv = 1'b0;
	logic dv = 1'b0;
	mmu_pkg::req_s ir = '0;
	mmu_pkg::req_s dr = '0;
	logic ready, rv, wreq, wdone, wfnd, pfnd = 1'b1;
	mmu_pkg::resp_s rsp;
	logic [mmu_pkg::VADDR_W-1:0] wva, lva;
	mmu_pkg::pte_s wpte, ppte = '0;
	logic [3:0] plat = '0;
	int walks;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	mmu_pkg::seg_s segs [16];
	mmu_pkg::blk_s blks [2][4];
	logic exp_walk;

	always #5 clk = ~clk;

	mmu_xlate_fault i_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .instr_xlate_enable_i(ixe),
		.data_xlate_enable_i(dxe), .seg_wr_i(seg_wr), .seg_wr_idx_i(seg_idx),
		.seg_wr_data_i(seg_d), .blk_wr_i(blk_wr), .blk_wr_instr_i(blk_i),
		.blk_wr_idx_i(blk_idx), .blk_wr_entry_i(blk_d), .tlb_flush_i(flush),
		.instr_req_valid_i(iv), .instr_req_i(ir), .data_req_valid_i(dv), .data_req_i(dr),
		.req_ready_o(ready), .resp_valid_o(rv), .resp_o(rsp), .walk_req_o(wreq),
		.walk_vaddr_o(wva), .walk_done_i(wdone), .walk_found_i(wfnd), .walk_pte_i(wpte));

	page_table_model i_pt (.sys_clk_i(clk), .walk_req_i(wreq), .walk_vaddr_i(wva),
		.walk_done_o(wdone), .walk_found_o(wfnd), .walk_pte_o(wpte), .found_i(pfnd),
		.pte_i(ppte), .lat_i(plat), .walks_o(walks), .last_va_o(lva));

	task automatic test_done();
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	// Roughly ten to fifteen cycles per iteration; the ceiling leaves a wide margin.
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			err_count = err_count + 1;
			test_done();
		end
	end

	task automatic chk(input logic ok, input string msg);
		tests_run = tests_run + 1;
		if (!ok) begin
			err_count = err_count + 1;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk

	task automatic strobe(input int kind);
		seg_wr = (kind == 0);
		blk_wr = (kind == 1);
		flush = (kind == 2);
		@(negedge clk);
		{seg_wr, blk_wr, flush} = 3'h0;
		@(negedge clk);
	endtask : strobe

	function automatic logic bmatch(input mmu_pkg::blk_s b, input mmu_pkg::req_s r);
		return b.valid && ((b.bepi ^ r.effective_addr[31:17]) & ~{4'h0, b.len_mask}) == 15'h0 &&
			(r.supervisor ? b.sup_valid : b.user_valid);
	endfunction : bmatch

	function automatic mmu_pkg::resp_s expect_f(input logic ii, input mmu_pkg::req_s r,
		input logic xe);
		mmu_pkg::resp_s e;
		mmu_pkg::seg_s s;
		mmu_pkg::blk_s b;
		logic hit;
		logic key;
		int st;
		e = '0;
		hit = 1'b0;
		st = 0;
		b = '0;
		exp_walk = 1'b0;
		s = segs[r.effective_addr[31:28]];
		for (int k = 3; k >= 0; k--) begin
			if (bmatch(blks[ii][k], r)) begin
				hit = 1'b1;
				b = blks[ii][k];
			end
		end
		if (!xe)
			e.phys_addr = r.effective_addr;
		else if (hit) begin
			if (ii && b.block_guarded_bit)
				st = 3;
			else if (b.pp == mmu_pkg::PP_NONE || (r.store && b.pp != mmu_pkg::PP_RW))
				st = 4;
			else
				e.phys_addr = {(b.brpn & ~{4'h0, b.len_mask})
					| (r.effective_addr[31:17] & {4'h0, b.len_mask}), r.effective_addr[16:0]};
		end else if (s.direct_store_select)
			st = ii ? 3 : 5;
		else if (ii && s.no_exec_bit)
			st = 3;
		else begin
			exp_walk = 1'b1;
			key = r.supervisor ? s.key_sup : s.key_user;
			if (!pfnd)
				st = 1;
			else if (ii && ppte.page_guarded_bit)
				st = 3;
			else if ((key && ppte.pp == 2'h0) || (r.store && (key ? ppte.pp != 2'h2 : ppte.pp == 2'h3)))
				st = 4;
			else
				e.phys_addr = {ppte.rpn, r.effective_addr[11:0]};
		end
		e.is_instr = ii;
		if (st != 0) begin
			e.fault_pc = r.pc;
			e.fault_ea = r.effective_addr;
			e.instr_storage_exception = ii;
			e.data_storage_exception = !ii;
			if (ii)
				e.save_restore_status = mmu_pkg::ST_BIT0 >> st;
			else
				e.data_fault_status = mmu_pkg::ST_BIT0 >> st;
		end
		return e;
	endfunction : expect_f

	task automatic access(input logic ii, input mmu_pkg::req_s r, output mmu_pkg::resp_s g);
		int n;
		n = 0;
		ir = r;
		dr = r;
		iv = ii;
		dv = !ii;
		while (ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		iv = 1'b0;
		dv = 1'b0;
		while (rv !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		g = rsp;
		chk(n < 200, "no response");
	endtask : access

	initial begin
		mmu_pkg::req_s r;
		mmu_pkg::resp_s e;
		mmu_pkg::resp_s g;
		logic [63:0] rnd;
		logic ii;
		logic xe;
		int w0;
		void'($urandom(73));
		repeat (8) @(negedge clk);
		chk(ready === 1'b0 && rv === 1'b0 && wreq === 1'b0, "outputs active in reset");
		rst_b = 1'b1;
		@(negedge clk);
		chk(ready === 1'b1, "not ready after reset");
		for (int k = 0; k < 8; k++) begin
			rnd = {$urandom, $urandom};
			blk_d = rnd[$bits(blk_d)-1:0];
			blk_d.valid = (k != 7);
			blk_i = k[0];
			blk_idx = k[2:1];
			blks[blk_i][blk_idx] = blk_d;
			strobe(1);
		end
		for (int i = 0; i < 300; i++) begin
			ii = $urandom % 2;
			xe = (i < 8) || ($urandom % 4 != 0);
			r.effective_addr = $urandom;
			r.pc = $urandom;
			r.store = !ii && ($urandom % 2);
			r.supervisor = $urandom % 2;
			if (i > 8 && $urandom % 3 == 0)
				r.effective_addr[31:17] = blks[ii][$urandom % 4].bepi;
			rnd = {$urandom, $urandom};
			seg_d = rnd[$bits(seg_d)-1:0];
			seg_d.direct_store_select = (i < 2) || ($urandom % 8 == 0);
			seg_d.no_exec_bit = (i == 2) || ($urandom % 8 == 0);
			seg_idx = r.effective_addr[31:28];
			segs[seg_idx] = seg_d;
			strobe(0);
			strobe(2);
			pfnd = (i != 3) && ($urandom % 5 != 0);
			ppte = rnd[63:41];
			plat = $urandom % 6;
			ixe = ii ? xe : $urandom % 2;
			dxe = ii ? $urandom % 2 : xe;
			e = expect_f(ii, r, xe);
			for (int p = 0; p < 2; p++) begin
				w0 = walks;
				access(ii, r, g);
				chk(g[$bits(g)-1:64] === e[$bits(e)-1:64], "result");
				if (e.instr_storage_exception || e.data_storage_exception)
					chk(g[63:0] === e[63:0], "fault addresses");
				chk(walks == w0 + (exp_walk && (p == 0 || !pfnd)), "search count");
				if (exp_walk && walks != w0)
					chk(lva === {seg_d.vsid, r.effective_addr[27:0]}, "virtual address");
			end
		end
		test_done();
	end
endmodule : tb_mmu_xlate_fault

`default_nettype wire
